// ---- hdl/fvp_poller.sv ----
// variable poller of a four-channel field-instrument analog input: reservation, polling, quality
// assumes one 40 MHz clock, a classic wishbone master, and a link engine that carries the
// selected command to the instrument and returns one reply per command
`timescale 1ns/1ps
`default_nettype none
`include "fvp_map.svh"

module fvp_poller #(
  parameter int unsigned RESERVE_CYCLES = `FVP_RESERVE_MS * (`FVP_CLK_HZ / 1000)
) (
  input wire logic clk_i,                 // system clock, 40 MHz
  input wire logic rst_i,                 // synchronous reset, active high
  input wire logic wb_cyc_i,              // wishbone cycle
  input wire logic wb_stb_i,              // wishbone strobe
  input wire logic wb_we_i,               // wishbone write
  input wire logic [7:0] wb_adr_i,        // wishbone byte address
  input wire logic [3:0] wb_sel_i,        // wishbone byte enables
  input wire logic [31:0] wb_dat_i,       // wishbone write data
  output logic [31:0] wb_dat_o,           // wishbone read data
  output logic wb_ack_o,                  // wishbone acknowledge
  input wire logic cmd_req_i,             // external command pending
  input wire logic [1:0] cmd_chan_i,      // channel of the external command
  input wire logic successive_command_flag_i, // external command is part of a sequence
  output logic cmd_ack_o,                 // external command taken for sending
  output logic cmd_rej_o,                 // external command refused
  output logic poll_req_o,                // own poll command issued
  output logic [1:0] poll_chan_o,         // channel of the poll
  output logic [7:0] poll_cmd_o,          // poll command number
  input wire logic rsp_valid_i,           // reply to the outstanding command
  input wire logic rsp_comm_err_i,        // link reported a communication error
  input wire logic rsp_via_cmd3_i,        // rev 7+ reply had to come from command 3
  input wire logic [7:0] rsp_code_i,      // response code of the reply
  input wire logic [7:0] rsp_status1_i,   // first status byte
  input wire logic [7:0] rsp_status2_i,   // second status byte
  input wire logic [3:0] rsp_var_present_i, // variable exists, one bit per variable
  input wire logic [127:0] rsp_value_i,   // four real values, variable 0 lowest
  input wire logic [31:0] rsp_dvs_i,      // four per_variable_status bytes
  input wire logic [3:0] failover_i       // redundancy failover put channel into standby
);

  // ----------------------------------------------------------------
  // quality code forming
  // ----------------------------------------------------------------
  function automatic logic [7:0] qual_calc(input logic rev7, input logic via_cmd3,
                                           input logic comm, input logic present,
                                           input logic [7:0] rc, input logic [7:0] s2,
                                           input logic [7:0] per_variable_status);
    logic [1:0] lim;
    logic [1:0] proc_st;
    lim = per_variable_status[`FVP_DVS_LIM_MSB -: 2];
    proc_st = per_variable_status[`FVP_DVS_PROC_MSB -: 2];
    // errors and response codes come first so a good status never masks them
    if (comm || !present) begin
      qual_calc = `FVP_Q_COMM_ERR;
    end else if (rc == `FVP_RC_ACCESS_RESTR) begin
      qual_calc = `FVP_Q_ACCESS_RESTR;
    end else if (rc == `FVP_RC_UPDATE_ERR) begin
      qual_calc = `FVP_Q_UPDATE_ERR;
    end else if (rev7) begin
      if (via_cmd3) begin
        qual_calc = `FVP_Q_VIA_CMD3;
      end else if (proc_st == 2'b00) begin
        qual_calc = `FVP_Q_BAD | {6'h00, lim};
      end else if (proc_st == 2'b01) begin
        qual_calc = `FVP_Q_POOR | {6'h00, lim};
      end else if (proc_st == 2'b10) begin
        qual_calc = `FVP_Q_MANUAL | {6'h00, lim};
      end else if (per_variable_status[`FVP_DVS_MORE]) begin
        qual_calc = `FVP_Q_MORE | {6'h00, lim};
      end else if (lim == 2'b00) begin
        qual_calc = `FVP_Q_GOOD;
      end else begin
        qual_calc = `FVP_Q_GOOD_LIM | {6'h00, lim};
      end
    end else if (s2[`FVP_S2_MORE_STATUS] || s2[`FVP_S2_CUR_SAT] ||
                 s2[`FVP_S2_SEC_LIMIT] || s2[`FVP_S2_PRI_RANGE]) begin
      qual_calc = `FVP_Q_UNCERTAIN;
    end else begin
      // configuration changed, cold start, fixed current and device error stay good
      qual_calc = `FVP_Q_GOOD;
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  fvp_pkg::fvp_regs_type r;
  fvp_pkg::fvp_regs_type n;
  logic acc_ext;
  logic rej_ext;
  logic wb_hit;
  logic [31:0] rd_data;
  logic [3:0] rec_idx;
  logic any_en;

  assign wb_hit = wb_cyc_i && wb_stb_i && !r.wb_ack;
  assign rec_idx = wb_adr_i[6:3];
  assign any_en = |r.chan_en;

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  always_comb begin
    if (wb_adr_i == `FVP_ADR_CTRL) begin
      rd_data = {24'h000000, r.chan_rev7, r.chan_en};
    end else if (wb_adr_i == `FVP_ADR_STATUS) begin
      rd_data = {16'h0000, `FVP_RECORD_ID, 1'b0, r.poll_chan, r.res_chan, r.res_active,
                 r.st};
    end else if (wb_adr_i[`FVP_REC_BASE_BIT] && wb_adr_i[1:0] == 2'b00) begin
      // record area: even word value, odd word quality, readable at any time
      if (wb_adr_i[2]) begin
        rd_data = {24'h000000, r.rec_q[rec_idx]};
      end else begin
        rd_data = r.rec_val[rec_idx];
      end
    end else begin
      rd_data = 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic found;
    logic [1:0] pick;
    logic [1:0] cand;
    logic [3:0] base;
    n = r;
    acc_ext = 1'b0;
    rej_ext = 1'b0;
    found = 1'b0;
    pick = 2'b00;
    cand = 2'b00;
    base = 4'h0;
    n.wb_ack = 1'b0;
    n.poll_req = 1'b0;

    // bus slave: every access is answered one cycle later, unmapped reads give zero
    if (wb_hit) begin
      n.wb_ack = 1'b1;
      n.wb_dat = rd_data;
      if (wb_we_i && wb_adr_i == `FVP_ADR_CTRL && wb_sel_i[0]) begin
        n.chan_en = wb_dat_i[`FVP_CTRL_EN_LSB +: 4];
        n.chan_rev7 = wb_dat_i[`FVP_CTRL_REV7_LSB +: 4];
      end
    end

    // reservation window runs out two seconds after the last flagged command
    if (r.res_active) begin
      if (r.res_timer <= 32'd1) begin
        n.res_active = 1'b0;
        n.res_timer = 32'h00000000;
      end else begin
        n.res_timer = r.res_timer - 32'd1;
      end
    end

    case (r.st)
      fvp_pkg::FVP_IDLE: begin
        if (cmd_req_i && r.res_active && cmd_chan_i != r.res_chan) begin
          rej_ext = 1'b1;
        end else if (cmd_req_i && (r.prefer_ext || !any_en || r.res_active)) begin
          acc_ext = 1'b1;
          n.st = fvp_pkg::FVP_EXT_WAIT;
          n.prefer_ext = 1'b0;
          if (successive_command_flag_i) begin
            n.res_active = 1'b1;
            n.res_chan = cmd_chan_i;
            n.res_timer = 32'(RESERVE_CYCLES);
          end else begin
            n.res_active = 1'b0;
            n.res_timer = 32'h00000000;
          end
        end
        // polling stops entirely while any channel is reserved
        if (!acc_ext && !rej_ext && !r.res_active && any_en) begin
          for (int k = 1; k <= `FVP_NUM_CHAN; k++) begin
            cand = r.poll_chan + 2'(k);
            if (!found && r.chan_en[cand]) begin
              found = 1'b1;
              pick = cand;
            end
          end
          n.poll_req = 1'b1;
          n.poll_chan = pick;
          n.poll_cmd = r.chan_rev7[pick] ? `FVP_CMD_READ_DVS : `FVP_CMD_READ_DYN;
          n.st = fvp_pkg::FVP_POLL_WAIT;
          n.prefer_ext = 1'b1;
        end
      end
      fvp_pkg::FVP_POLL_WAIT: begin
        if (rsp_valid_i) begin
          n.st = fvp_pkg::FVP_IDLE;
          if (!r.res_active) begin
            base = {r.poll_chan, 2'b00};
            for (int v = 0; v < `FVP_NUM_VAR; v++) begin
              n.rec_q[base + 4'(v)] = qual_calc(r.chan_rev7[r.poll_chan], rsp_via_cmd3_i,
                                                rsp_comm_err_i ||
                                                rsp_status1_i[`FVP_S1_COMM_ERR],
                                                rsp_var_present_i[v], rsp_code_i,
                                                rsp_status2_i, rsp_dvs_i[8*v +: 8]);
              // a failed read keeps the last value and only the quality tells
              if (!rsp_comm_err_i && !rsp_status1_i[`FVP_S1_COMM_ERR] &&
                  rsp_var_present_i[v]) begin
                n.rec_val[base + 4'(v)] = rsp_value_i[32*v +: 32];
              end
            end
          end
        end
      end
      fvp_pkg::FVP_EXT_WAIT: begin
        if (rsp_valid_i) begin
          n.st = fvp_pkg::FVP_IDLE;
        end
      end
      default: begin
        n.st = fvp_pkg::FVP_IDLE;
      end
    endcase

    // standby after failover overrides whatever quality the poll just wrote; the value it wrote stays
    for (int c = 0; c < `FVP_NUM_CHAN; c++) begin
      if (failover_i[c]) begin
        for (int v = 0; v < `FVP_NUM_VAR; v++) begin
          n.rec_q[4 * c + v] = `FVP_Q_INIT;
        end
      end
    end

    if (rst_i) begin
      n = '0;
      for (int i = 0; i < `FVP_NUM_REC; i++) begin
        n.rec_q[i] = `FVP_Q_INIT;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    r <= n;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = r.wb_ack;
  assign wb_dat_o = r.wb_dat;
  assign cmd_ack_o = acc_ext;
  assign cmd_rej_o = rej_ext;
  assign poll_req_o = r.poll_req;
  assign poll_chan_o = r.poll_chan;
  assign poll_cmd_o = r.poll_cmd;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_reserve_start: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_ack_o && successive_command_flag_i && !failover_i[0]
    |=> r.res_active && r.res_chan == $past(cmd_chan_i))
    else $error("flagged command did not reserve its channel");

  a_reserve_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_ack_o && successive_command_flag_i |=> r.res_timer == RESERVE_CYCLES)
    else $error("reservation window not restarted");

  a_release_plain: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_ack_o && !successive_command_flag_i |=> !r.res_active)
    else $error("unflagged command left the reservation standing");

  a_release_timeout: assert property (@(posedge clk_i) disable iff (rst_i)
    r.res_active && r.res_timer == 32'd1 && !cmd_ack_o |=> !r.res_active)
    else $error("reservation outlived its window");

  a_poll_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
    r.res_active |-> ##1 !poll_req_o)
    else $error("poll issued while a channel is reserved");

  a_reject_other: assert property (@(posedge clk_i) disable iff (rst_i)
    r.st == fvp_pkg::FVP_IDLE && cmd_req_i && r.res_active && cmd_chan_i != r.res_chan
    |-> cmd_rej_o && !cmd_ack_o)
    else $error("command for another channel not refused");

  a_cmd_by_rev: assert property (@(posedge clk_i) disable iff (rst_i)
    poll_req_o |-> poll_cmd_o == (r.chan_rev7[poll_chan_o] ? 8'h09 : 8'h03))
    else $error("poll command does not match revision");

  a_comm_err_q: assert property (@(posedge clk_i) disable iff (rst_i)
    r.st == fvp_pkg::FVP_POLL_WAIT && rsp_valid_i && rsp_comm_err_i && !r.res_active &&
    failover_i == 4'h0 |=> r.rec_q[{r.poll_chan, 2'b00}] == 8'h23)
    else $error("communication error not reported as 23h");

  a_failover_init: assert property (@(posedge clk_i) disable iff (rst_i)
    failover_i[1] |=> r.rec_q[4] == 8'h37 && r.rec_q[7] == 8'h37)
    else $error("failover did not load the init quality");

  a_alternate: assert property (@(posedge clk_i) disable iff (rst_i)
    r.st == fvp_pkg::FVP_IDLE && cmd_req_i && r.prefer_ext && !r.res_active |-> cmd_ack_o)
    else $error("pending external command skipped its turn");

  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge held too long");

  a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus access not answered");

  a_init_quality: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> r.rec_q == {16{8'h37}})
    else $error("qualities not at init after reset");

  a_frozen_values: assert property (@(posedge clk_i) disable iff (rst_i)
    r.res_active |=> $stable(r.rec_val))
    else $error("value changed during reservation");

  a_frozen_quality: assert property (@(posedge clk_i) disable iff (rst_i)
    r.res_active && failover_i == 4'h0 |=> $stable(r.rec_q))
    else $error("quality changed during reservation");

  a_timer_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    r.res_timer <= RESERVE_CYCLES && (r.res_active || r.res_timer == 32'd0))
    else $error("reservation timer out of range");

  a_poll_enabled: assert property (@(posedge clk_i) disable iff (rst_i)
    poll_req_o |-> (($past(r.chan_en) >> poll_chan_o) & 4'h1) != 4'h0)
    else $error("poll sent to a disabled channel");

  a_one_at_a_time: assert property (@(posedge clk_i) disable iff (rst_i)
    r.st != fvp_pkg::FVP_IDLE |-> !cmd_ack_o && !cmd_rej_o)
    else $error("command taken while a reply is outstanding");

  a_ack_or_reject: assert property (@(posedge clk_i) disable iff (rst_i)
    !(cmd_ack_o && cmd_rej_o))
    else $error("command both taken and refused");

  a_update_err_q: assert property (@(posedge clk_i) disable iff (rst_i)
    r.st == fvp_pkg::FVP_POLL_WAIT && rsp_valid_i && rsp_code_i == 8'h08 &&
    !rsp_comm_err_i && !rsp_status1_i[7] && rsp_var_present_i[0] && !r.res_active &&
    failover_i == 4'h0 |=> r.rec_q[{r.poll_chan, 2'b00}] == 8'h84)
    else $error("update error not reported as 84h");

  a_access_q: assert property (@(posedge clk_i) disable iff (rst_i)
    r.st == fvp_pkg::FVP_POLL_WAIT && rsp_valid_i && rsp_code_i == 8'h10 &&
    !rsp_comm_err_i && !rsp_status1_i[7] && rsp_var_present_i[0] && !r.res_active &&
    failover_i == 4'h0 |=> r.rec_q[{r.poll_chan, 2'b00}] == 8'h24)
    else $error("access restriction not reported as 24h");

endmodule // fvp_poller

`default_nettype wire

// ---- hdl/fvp_map.svh ----
// offsets, field positions, reset values and timing figures of the variable poller
// assumes a 40 MHz system clock and a byte-addressed classic wishbone bus
`ifndef FVP_MAP_SVH
`define FVP_MAP_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define FVP_NUM_CHAN 4
`define FVP_NUM_VAR 4
`define FVP_NUM_REC 16

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FVP_CLK_HZ 40000000
`define FVP_RESERVE_MS 2000

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define FVP_ADR_CTRL 8'h00
`define FVP_ADR_STATUS 8'h04
`define FVP_REC_BASE_BIT 7
`define FVP_RECORD_ID 8'h79

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define FVP_CTRL_EN_LSB 0
`define FVP_CTRL_REV7_LSB 4

// ----------------------------------------------------------------
// commands and response codes
// ----------------------------------------------------------------
`define FVP_CMD_READ_DYN 8'h03
`define FVP_CMD_READ_DVS 8'h09
`define FVP_RC_UPDATE_ERR 8'h08
`define FVP_RC_ACCESS_RESTR 8'h10

// ----------------------------------------------------------------
// status byte fields
// ----------------------------------------------------------------
`define FVP_S1_COMM_ERR 7
`define FVP_S2_DEV_ERR 7
`define FVP_S2_CFG_CHANGED 6
`define FVP_S2_COLD_START 5
`define FVP_S2_MORE_STATUS 4
`define FVP_S2_FIXED_CUR 3
`define FVP_S2_CUR_SAT 2
`define FVP_S2_SEC_LIMIT 1
`define FVP_S2_PRI_RANGE 0
`define FVP_DVS_PROC_MSB 7
`define FVP_DVS_LIM_MSB 5
`define FVP_DVS_MORE 3

// ----------------------------------------------------------------
// quality codes
// ----------------------------------------------------------------
`define FVP_Q_GOOD 8'h80
`define FVP_Q_UNCERTAIN 8'h78
`define FVP_Q_UPDATE_ERR 8'h84
`define FVP_Q_ACCESS_RESTR 8'h24
`define FVP_Q_COMM_ERR 8'h23
`define FVP_Q_INIT 8'h37
`define FVP_Q_VIA_CMD3 8'h40
`define FVP_Q_GOOD_LIM 8'h88
`define FVP_Q_BAD 8'h28
`define FVP_Q_POOR 8'h68
`define FVP_Q_MANUAL 8'h78
`define FVP_Q_MORE 8'h88

`endif

// ---- hdl/fvp_pkg.sv ----
// types of the variable poller: controller states and the registered state record
// assumes fvp_map.svh is on the include path
`include "fvp_map.svh"

package fvp_pkg;

  typedef enum logic [1:0] {
    FVP_IDLE,
    FVP_POLL_WAIT,
    FVP_EXT_WAIT
  } fvp_state_type;

  typedef struct packed {
    fvp_state_type st;
    logic prefer_ext;
    logic res_active;
    logic [1:0] res_chan;
    logic [31:0] res_timer;
    logic [1:0] poll_chan;
    logic poll_req;
    logic [7:0] poll_cmd;
    logic [3:0] chan_en;
    logic [3:0] chan_rev7;
    logic wb_ack;
    logic [31:0] wb_dat;
    logic [`FVP_NUM_REC-1:0][31:0] rec_val;
    logic [`FVP_NUM_REC-1:0][7:0] rec_q;
  } fvp_regs_type;

endpackage

// ---- dv/fvp_inst_model.sv ----
// behavioural field instrument: one reply per poll or accepted external command
// assumes the bench sets the reply contents and the reply delay between polls
`timescale 1ns/1ps
`default_nettype none

module fvp_inst_model (
  input wire logic clk_i,           // system clock
  input wire logic rst_i,           // synchronous reset
  input wire logic poll_req_i,      // poll issued by the block
  input wire logic cmd_ack_i,       // external command sent by the block
  input wire logic [3:0] dly_i,     // reply delay in cycles
  input wire logic [7:0] code_i,    // response code to return
  input wire logic [7:0] s1_i,      // first status byte to return
  input wire logic [7:0] s2_i,      // second status byte to return
  input wire logic [3:0] pres_i,    // variables present
  input wire logic [127:0] val_i,   // values to return
  input wire logic [31:0] dvs_i,    // per variable status to return
  input wire logic comm_i,          // report a link error
  input wire logic via3_i,          // report fallback to command 3
  output logic rsp_valid_o,         // reply pulse
  output logic [7:0] rsp_code_o,    // reply response code
  output logic [7:0] rsp_s1_o,      // reply status 1
  output logic [7:0] rsp_s2_o,      // reply status 2
  output logic [3:0] rsp_pres_o,    // reply presence
  output logic [127:0] rsp_val_o,   // reply values
  output logic [31:0] rsp_dvs_o,    // reply variable status
  output logic rsp_comm_o,          // reply link error
  output logic rsp_via3_o,          // reply fallback flag
  output logic [15:0] nrsp_o        // replies given so far
);
  logic busy;
  logic [3:0] cnt;

  // ----------------------------------------------------------------
  // reply timing
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    rsp_valid_o <= 1'b0;
    if (rst_i) begin
      busy <= 1'b0;
      nrsp_o <= 16'h0000;
    end else if (!busy && (poll_req_i || cmd_ack_i)) begin
      busy <= 1'b1;
      cnt <= dly_i;
    end else if (busy && cnt == 4'h0) begin
      busy <= 1'b0;
      rsp_valid_o <= 1'b1;
      nrsp_o <= nrsp_o + 16'h0001;
    end else if (busy) begin
      cnt <= cnt - 4'h1;
    end
  end

  // outside a reply the lines carry the inverse so stale data never looks valid
  assign rsp_code_o = rsp_valid_o ? code_i : ~code_i;
  assign rsp_s1_o = rsp_valid_o ? s1_i : ~s1_i;
  assign rsp_s2_o = rsp_valid_o ? s2_i : ~s2_i;
  assign rsp_pres_o = rsp_valid_o ? pres_i : ~pres_i;
  assign rsp_val_o = rsp_valid_o ? val_i : ~val_i;
  assign rsp_dvs_o = rsp_valid_o ? dvs_i : ~dvs_i;
  assign rsp_comm_o = rsp_valid_o ? comm_i : ~comm_i;
  assign rsp_via3_o = rsp_valid_o ? via3_i : ~via3_i;
endmodule // fvp_inst_model
`default_nettype wire

// ---- dv/fvp_poller_test.sv ----
// self-checking bench of the variable poller, with a behavioural instrument
// assumes fvp_map.svh on the include path; reservation shortened to 60 cycles
`timescale 1ns/1ps
`default_nettype none
`include "fvp_map.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end

module fvp_poller_test;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, creq = 0, cflag = 0, vld, comm, via3;
  logic m_comm = 0, m_via3 = 0, wb_ack_o, cmd_ack_o, cmd_rej_o, poll_req_o;
  logic [7:0] adr = 0, m_code = 0, m_s1 = 0, m_s2 = 0, code, s1, s2, poll_cmd_o;
  logic [1:0] cchan = 0, poll_chan_o;
  logic [3:0] m_pres = 4'hf, m_dly = 0, pres, fo = 0;
  logic [31:0] wdat = 0, m_dvs = 0, per_variable_status, wb_dat_o;
  logic [127:0] m_val = 0, val;
  logic [15:0] nrsp;
  logic [31:0] exp_q[$], msk_q[$];
  logic exp_c[$];
  int errors = 0, num_checks = 0;
  // code, status1, status2 or variable status, {comm, via3, 2'b0, present}, quality
  logic [39:0] t5 [10] = '{40'h0000100f78, 40'h0000040f78, 40'h0000020f78, 40'h0000010f78,
    40'h0000800f80, 40'h0800000f84, 40'h1000100f24, 40'h0000008f23, 40'h0080000f23,
    40'h0800000023};
  logic [39:0] t7 [12] = '{40'h0000c00f80, 40'h0000d00f89, 40'h0000e00f8a, 40'h0000000f28,
    40'h0000300f2b, 40'h0000400f68, 40'h0000800f78, 40'h0000b00f7b, 40'h0000c80f88,
    40'h0000c04f40, 40'h0800c04f84, 40'h0080c00f23};

  always #12.5 clk_i = ~clk_i;

  fvp_poller #(.RESERVE_CYCLES(60)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmd_req_i(creq), .cmd_chan_i(cchan),
    .successive_command_flag_i(cflag), .cmd_ack_o(cmd_ack_o), .cmd_rej_o(cmd_rej_o),
    .poll_req_o(poll_req_o), .poll_chan_o(poll_chan_o), .poll_cmd_o(poll_cmd_o),
    .rsp_valid_i(vld), .rsp_comm_err_i(comm), .rsp_via_cmd3_i(via3), .rsp_code_i(code),
    .rsp_status1_i(s1), .rsp_status2_i(s2), .rsp_var_present_i(pres), .rsp_value_i(val),
    .rsp_dvs_i(per_variable_status), .failover_i(fo));

  fvp_inst_model u_inst (.clk_i(clk_i), .rst_i(rst_i), .poll_req_i(poll_req_o),
    .cmd_ack_i(cmd_ack_o), .dly_i(m_dly), .code_i(m_code), .s1_i(m_s1), .s2_i(m_s2),
    .pres_i(m_pres), .val_i(m_val), .dvs_i(m_dvs), .comm_i(m_comm), .via3_i(m_via3),
    .rsp_valid_o(vld), .rsp_code_o(code), .rsp_s1_o(s1), .rsp_s2_o(s2), .rsp_pres_o(pres),
    .rsp_val_o(val), .rsp_dvs_o(per_variable_status), .rsp_comm_o(comm), .rsp_via3_o(via3), .nrsp_o(nrsp));

  // ----------------------------------------------------------------
  // closing and bus tasks
  // ----------------------------------------------------------------
  task tally_and_finish;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    n = 0;
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin errors++; tally_and_finish; end
    cyc <= 0; stb <= 0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e); msk_q.push_back(m);
    wb(1'b0, a, 32'h0);
  endtask

  // an external command is held until the block takes or refuses it
  task cmd(input logic [1:0] c, input logic f, input logic acc);
    int n;
    exp_c.push_back(acc);
    @(posedge clk_i);
    creq <= 1; cchan <= c; cflag <= f;
    n = 0;
    do begin @(posedge clk_i); n++; end while ((cmd_ack_o | cmd_rej_o) !== 1'b1 && n < 200);
    if (n >= 200) begin errors++; tally_and_finish; end
    creq <= 0;
  endtask

  task setrsp(input logic [39:0] t);
    int s, n;
    @(posedge clk_i);
    m_code <= t[39:32]; m_s1 <= t[31:24]; m_s2 <= t[23:16]; m_dvs <= {4{t[23:16]}};
    m_comm <= t[15]; m_via3 <= t[14]; m_pres <= t[11:8];
    m_dly <= 4'($urandom % 9); m_val <= {$urandom, $urandom, $urandom, $urandom};
    // two fresh replies guarantee the record holds the new contents
    s = nrsp; n = 0;
    while (nrsp < s + 2 && n < 500) begin @(posedge clk_i); n++; end
    if (n >= 500) begin errors++; tally_and_finish; end
  endtask

  function automatic logic [7:0] ra(input int ch, input int v);
    return 8'h80 + 8'(8 * (4 * ch + v));
  endfunction

  // ----------------------------------------------------------------
  // result watcher
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      `CHK("wb_dat_o", exp_q[0], wb_dat_o & msk_q[0])
      void'(exp_q.pop_front()); void'(msk_q.pop_front());
    end
    if (poll_req_o === 1'b1) `CHK("poll_cmd_o", poll_chan_o == 2'd1 ? 8'h09 : 8'h03, poll_cmd_o)
    if ((cmd_ack_o | cmd_rej_o) === 1'b1 && exp_c.size() > 0) begin
      `CHK("cmd_ack_o", exp_c[0], cmd_ack_o)
      void'(exp_c.pop_front());
    end
  end

  initial begin repeat (100000) @(posedge clk_i); errors++; tally_and_finish; end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(52));
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    for (int v = 0; v < 4; v++) rd(ra(0, v) + 8'h04, 32'h37, 32'hff);
    rd(`FVP_ADR_STATUS, 32'h7900, 32'hff00);
    rd(8'h40, 32'h0, 32'hffffffff);
    wb(1'b1, `FVP_ADR_CTRL, 32'h21);
    rd(`FVP_ADR_CTRL, 32'h21, 32'hff);
    setrsp(40'h0000680f00);
    for (int v = 0; v < 4; v++) begin
      rd(ra(0, v), m_val[32*v+:32], 32'hffffffff);
      rd(ra(0, v) + 8'h04, 32'h80, 32'hff);
    end
    for (int i = 0; i < 10; i++) begin
      setrsp(t5[i]);
      rd(ra(0, i % 4) + 8'h04, {24'h0, t5[i][7:0]}, 32'hff);
    end
    wb(1'b1, `FVP_ADR_CTRL, 32'h22);
    for (int i = 0; i < 12; i++) begin
      setrsp(t7[i]);
      rd(ra(1, i % 4) + 8'h04, {24'h0, t7[i][7:0]}, 32'hff);
    end
    wb(1'b1, `FVP_ADR_CTRL, 32'h20);
    repeat (20) @(posedge clk_i);
    fo <= 4'h2;
    @(posedge clk_i);
    fo <= 4'h0;
    for (int v = 0; v < 4; v++) rd(ra(1, v) + 8'h04, 32'h37, 32'hff);
    wb(1'b1, `FVP_ADR_CTRL, 32'h21);
    setrsp(40'h0000000f00);
    cmd(2'd0, 1'b1, 1'b1);
    rd(`FVP_ADR_STATUS, 32'h4, 32'h1c);
    @(posedge clk_i);
    m_code <= 8'h08;
    cmd(2'd1, 1'b0, 1'b0);
    repeat (30) @(posedge clk_i);
    cmd(2'd0, 1'b1, 1'b1);
    rd(ra(0, 0) + 8'h04, 32'h80, 32'hff);
    repeat (40) @(posedge clk_i);
    cmd(2'd1, 1'b0, 1'b0);
    repeat (70) @(posedge clk_i);
    cmd(2'd1, 1'b0, 1'b1);
    rd(`FVP_ADR_STATUS, 32'h0, 32'h4);
    cmd(2'd0, 1'b1, 1'b1);
    cmd(2'd0, 1'b0, 1'b1);
    rd(`FVP_ADR_STATUS, 32'h0, 32'h4);
    setrsp(40'h0800000f00);
    rd(ra(0, 0) + 8'h04, 32'h84, 32'hff);
    tally_and_finish;
  end
endmodule // fvp_poller_test
`default_nettype wire
